// *** srrm_consts.vh ***
`ifndef SRRM_CONSTS_VH
`define SRRM_CONSTS_VH

// readback command pattern in word bits [4:0] (only bit 3 set)
`define SRRM_CMD_LSB 0
`define SRRM_CMD_MSB 4
`define SRRM_CMD_RDBK 5'h08
// register address field of a command word
`define SRRM_ADDR_LSB 28
`define SRRM_ADDR_MSB 31
`define SRRM_ADDR_W 4
// status word field positions
`define SRRM_SEL_LSB 0
`define SRRM_SEL_MSB 3
`define SRRM_BANK_BIT 4
`define SRRM_VER_LSB 5
`define SRRM_VER_MSB 6
`define SRRM_UNUSED_LSB 7
`define SRRM_UNUSED_MSB 15
`define SRRM_Q_LSB 16
`define SRRM_Q_MSB 23
`define SRRM_I_LSB 24
`define SRRM_I_MSB 31
// reset values
`define SRRM_DAC_RESET 8'h80
`define SRRM_SEL_RESET 4'h8
`define SRRM_BANK_RESET 1'h0
`define SRRM_SETUP5_USED_MSB 16
`define SRRM_SETUP5_RESET 32'h00000000
// setup register five address (write command bits [3:0], bit 4 clear)
`define SRRM_ADDR_SETUP5 4'h5
`define SRRM_ADDR_STATUS 4'h0
// word length of the serial link
`define SRRM_WORD_BITS 32
`define SRRM_CNT_W 6
// counter value while the last status bit stands on the pin
`define SRRM_LAST_BIT 6'h1f

`endif

// *** srrm_shift32.v ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// word shifter: lsb-first capture and send
// ----------------------------------------
module srrm_shift32 #(
	parameter WIDTH = 32
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// controls, one-cycle enables
	input wire shift_in_en,
	input wire in_bit,
	input wire load_en,
	input wire [WIDTH-1:0] load_word,
	input wire shift_out_en,
	// state
	output reg [WIDTH-1:0] in_word_reg,
	output reg [WIDTH-1:0] out_word_reg
);

	// incoming bits land at the top so the first bit ends at bit 0
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_word_reg <= {WIDTH{1'b0}};
		end else if (shift_in_en) begin
			in_word_reg <= {in_bit, in_word_reg[WIDTH-1:1]};
		end
	end

	// outgoing word drains from bit 0 upward
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_word_reg <= {WIDTH{1'b0}};
		end else if (load_en) begin
			out_word_reg <= load_word;
		end else if (shift_out_en) begin
			out_word_reg <= {1'b0, out_word_reg[WIDTH-1:1]};
		end
	end

endmodule

`default_nettype wire

// *** srrm_readback.v ***
// Function
// - status low bits name selected setup register
// - bit four reports serial bank select
// - bits five, six hold fixed version code
// - q dac state bits 16-23, reset 0x80
// - i dac state bits 24-31, reset 0x80
// - unused setup5 high bits, status 7-15 zero
// - both dacs start half scale, hold values
`timescale 1ns/1ps
`default_nettype none
`include "srrm_consts.vh"

module srrm_readback #(
	parameter [1:0] VERSION_CODE = 2'h2 // arbitrary value
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// three-wire serial link pins and readback output
	input wire ser_clk,
	input wire ser_data,
	input wire ser_latch,
	output reg readback_out,
	// offset dac states from the calibration logic
	input wire cal_load,
	input wire [7:0] cal_i_value,
	input wire [7:0] cal_q_value,
	// setup register five contents
	output reg [31:0] setup_five_reg
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [2:0] sync1_reg;
	reg [2:0] sync2_reg;
	reg sclk_prev_reg;
	reg latch_prev_reg;

	// first stage is read only by the second stage
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// latch idles high: resetting to that level avoids a
			// false latch edge, and a stray command, after reset
			sync1_reg <= 3'h4;
			sync2_reg <= 3'h4;
			sclk_prev_reg <= 1'b0;
			latch_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {ser_latch, ser_data, ser_clk};
			sync2_reg <= sync1_reg;
			sclk_prev_reg <= sync2_reg[0];
			latch_prev_reg <= sync2_reg[2];
		end
	end

	wire sclk_rise = sync2_reg[0] & ~sclk_prev_reg;
	wire sclk_fall = ~sync2_reg[0] & sclk_prev_reg;
	wire latch_rise = sync2_reg[2] & ~latch_prev_reg;

	// ----------------------------------------
	// readback sequencer
	// ----------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SEND = 2'b10;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [`SRRM_CNT_W-1:0] cnt_reg;
	reg [7:0] i_dac_reg;
	reg [7:0] q_dac_reg;
	reg [3:0] sel_reg;
	reg bank_reg;
	wire [31:0] in_word;
	wire [31:0] out_word;
	wire [31:0] status_word;

	wire is_rdbk = in_word[`SRRM_CMD_MSB:`SRRM_CMD_LSB] == `SRRM_CMD_RDBK;
	wire [`SRRM_ADDR_W-1:0] cmd_addr = in_word[`SRRM_ADDR_MSB:`SRRM_ADDR_LSB];
	wire cmd_take = latch_rise & (state_reg == ST_IDLE);
	wire rdbk_take = cmd_take & is_rdbk;
	wire send_shift = (state_reg == ST_SEND) & sclk_fall;
	// the word is loaded in the cycle the command is taken, before the
	// select registers update, so it takes the fields from the command
	wire [3:0] sel_now = rdbk_take ? cmd_addr : sel_reg;
	wire bank_now = rdbk_take ? in_word[`SRRM_ADDR_LSB - 1] : bank_reg;

	// assemble the read-only word; version never comes from a write
	assign status_word = {i_dac_reg,
		q_dac_reg,
		9'h0,
		VERSION_CODE,
		bank_now,
		sel_now};

	srrm_shift32 #(
		.WIDTH(`SRRM_WORD_BITS)
	) u_shift (
		.clk(clk),
		.nrst(nrst),
		.shift_in_en(sclk_rise & ~sync2_reg[2]),
		.in_bit(sync2_reg[1]),
		.load_en(rdbk_take),
		.load_word(status_word),
		.shift_out_en(send_shift),
		.in_word_reg(in_word),
		.out_word_reg(out_word)
	);

	// next state: send exactly one word after a readback command
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (rdbk_take) begin
				state_next = ST_SEND;
			end
		end
		ST_SEND: begin
			if (send_shift && cnt_reg == `SRRM_LAST_BIT) begin
				state_next = ST_IDLE;
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end

	// state, bit counter and pin driver; bit 0 shows right after latch
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= {`SRRM_CNT_W{1'b0}};
			readback_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (rdbk_take) begin
				cnt_reg <= {`SRRM_CNT_W{1'b0}};
				readback_out <= status_word[0];
			end else if (send_shift) begin
				cnt_reg <= cnt_reg + 1'b1;
				readback_out <= out_word[1];
			end else if (state_reg == ST_IDLE) begin
				readback_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register writes and dac state
	// ----------------------------------------
	// select field echoes the register and bank of the last readback command
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_reg <= `SRRM_SEL_RESET;
			bank_reg <= `SRRM_BANK_RESET;
		end else if (rdbk_take) begin
			sel_reg <= cmd_addr;
			bank_reg <= in_word[`SRRM_ADDR_LSB - 1];
		end
	end

	// setup five: only low bits are stored, upper bits stay zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setup_five_reg <= `SRRM_SETUP5_RESET;
		end else if (cmd_take && !is_rdbk &&
			in_word[`SRRM_CMD_MSB:`SRRM_CMD_LSB] ==
			{1'b0, `SRRM_ADDR_SETUP5}) begin
			setup_five_reg <= {15'h0,
				in_word[`SRRM_SETUP5_USED_MSB:0]};
		end
	end

	// dacs hold half scale until a calibration delivers values
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			i_dac_reg <= `SRRM_DAC_RESET;
			q_dac_reg <= `SRRM_DAC_RESET;
		end else if (cal_load) begin
			i_dac_reg <= cal_i_value;
			q_dac_reg <= cal_q_value;
		end
	end

endmodule

`default_nettype wire

// *** srrm_readback_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// checks
// ----
module srrm_readback_checker (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// pins
	input wire logic ser_clk,
	input wire logic ser_latch,
	input wire logic readback_out,
	input wire logic cal_load,
	input wire logic [31:0] setup_five_reg
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// register five: top clear, changed only by a latched word
	AST_S5_TOP: assert property (
		setup_five_reg[31:17] == 15'h0) else $error("s5 top");
	AST_S5_LATCH: assert property (
		$changed(setup_five_reg) |-> ser_latch) else $error("s5 early");
	AST_S5_LAG: assert property (
		$changed(setup_five_reg) |-> $past(ser_latch, 2)) else $error("s5 lag");
	AST_S5_CAL: assert property (
		cal_load |=> $stable(setup_five_reg)) else $error("s5 by cal");
	// readback pin: quiet outside frames, settled late in a high phase
	AST_RB_IDLE: assert property (
		(!ser_latch) [*6] |-> !readback_out) else $error("rb busy");
	AST_RB_LATCH: assert property (
		readback_out |-> ser_latch) else $error("rb no latch");
	AST_RB_START: assert property (
		$rose(ser_latch) |-> (!readback_out) [*2]) else $error("rb early");
	AST_RB_HOLD: assert property (
		ser_clk [*4] |-> $stable(readback_out)) else $error("rb moved");
endmodule
bind srrm_readback srrm_readback_checker chk (.clk(clk), .nrst(nrst),
	.ser_clk(ser_clk), .ser_latch(ser_latch), .readback_out(readback_out),
	.cal_load(cal_load), .setup_five_reg(setup_five_reg));
`default_nettype wire

// *** srrm_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// host model
// ----
module srrm_host (
	// serial pins
	output logic ser_clk,
	output logic ser_data,
	output logic ser_latch,
	input wire logic readback_out
);
	logic [31:0] rd;
	event got;
	// idle: clock stands low, latch high
	initial begin
		ser_clk = 1'h0;
		ser_data = 1'h0;
		ser_latch = 1'h1;
	end
	// word out lsb first, then 32 bits back
	task automatic xfer(input logic [31:0] w);
		ser_latch = 1'h0;
		for (int i = 0; i < 32; i++) begin
			ser_data = w[i];
			#100 ser_clk = 1'h1;
			#100 ser_clk = 1'h0;
		end
		// released line must not keep the last bit
		#100 ser_data = ~ser_data;
		ser_latch = 1'h1;
		for (int k = 0; k < 32; k++) begin
			#100 ser_clk = 1'h1;
			#100 rd[k] = readback_out;
			ser_clk = 1'h0;
		end
		#200 -> got;
	endtask
endmodule
`default_nettype wire

// *** srrm_readback_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module srrm_readback_tb;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic cal_load = 1'h0;
	logic [7:0] ci = 8'h80;
	logic [7:0] cq = 8'h80;
	logic [31:0] s5x = 32'h0;
	logic [31:0] sd = 32'h4c99; // seed 19609
	logic [31:0] q[$];
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire logic sc, sdat, sl, rb;
	wire logic [31:0] s5;
	always #12.5 clk = ~clk;
	srrm_readback uut (.clk(clk), .nrst(nrst), .ser_clk(sc),
		.ser_data(sdat), .ser_latch(sl), .readback_out(rb),
		.cal_load(cal_load), .cal_i_value(ci), .cal_q_value(cq),
		.setup_five_reg(s5));
	srrm_host host (.ser_clk(sc), .ser_data(sdat), .ser_latch(sl),
		.readback_out(rb));
	function automatic logic [31:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string nm);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, well above twelve frames
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	// oldest notes against each finished frame
	always @(host.got) begin
		chk(host.rd, q.pop_front(), "readback");
		chk(s5, q.pop_front(), "setup five");
	end
	task automatic frame(input logic [31:0] w, input logic [31:0] e);
		q.push_back(e);
		q.push_back(s5x);
		host.xfer(w);
	endtask
	// status read, setup five write, new dac values; first read at reset
	initial begin
		logic [31:0] r;
		logic [11:0] t;
		repeat (5) @(negedge clk);
		nrst = 1'h1;
		repeat (3) @(negedge clk);
		for (int n = 0; n < 6; n++) begin
			r = rnd();
			frame({r[3:0] % 4'h5 + 4'h1, r[4], 22'h0, 5'h08},
				{ci, cq, 9'h0, 2'h2,
				r[4], r[3:0] % 4'h5 + 4'h1});
			t = n[0] ? 12'h64e : 12'h555;
			s5x = {15'h0, t, 5'h05};
			frame({r[31:17], t, 5'h05}, 32'h0);
			ci = r[15:8];
			cq = r[23:16];
			// frames end on a falling edge; wait for one so that the
			// pulse spans a full rising edge
			@(negedge clk);
			cal_load = 1'h1;
			@(negedge clk);
			cal_load = 1'h0;
		end
		end_sim();
	end
endmodule
`default_nettype wire
